// ==== irtx_defs.svh ====
// Constants of the infrared remote frame transmitter
// Summary of operation
// - Standard frame is fourteen bi-phase bits
// - Both start bits sent as one in standard mode
// - Toggle bit sent exactly as given
// - Five-bit system address follows toggle
// - Six-bit command field ends standard frame
// - Every bit coded bi-phase, mid-bit transition
// - Extended: second start bit selects bank
// - Timer compare pin makes waveform, no interrupts
// - Long variant sends sixteen-bit address-command word
// - Long variant header is twenty bits
// - Long variant address is eight bits
// - Long variant command is eight bits
`ifndef IRTX_DEFS_SVH
`define IRTX_DEFS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define IRTX_OFF_CTRL 4'h0
`define IRTX_OFF_TOGGLE 4'h1
`define IRTX_OFF_ADDR 4'h2
`define IRTX_OFF_CMD 4'h3
`define IRTX_OFF_STATUS 4'h4
`define IRTX_OFF_HALFBIT 4'h5
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define IRTX_CTRL_GO_BIT 0
`define IRTX_CTRL_MODE_LSB 1
`define IRTX_CTRL_INV_BIT 3
`define IRTX_STD_TOGGLE_BIT 5
`define IRTX_EXT_BANK_BIT 6
`define IRTX_EXT_TOGGLE_BIT 5
`define IRTX_STD_LEN 6'h0E
`define IRTX_LONG_HDR_LEN 6'h14
`define IRTX_LONG_DATA_LEN 6'h10
`define IRTX_LONG_LEN 6'h24
`define IRTX_HALFBIT_RST 16'h1BC7
`endif

// ==== irtx_pkg.sv ====
// Types of the infrared remote frame transmitter
package irtx_pkg;
	typedef enum logic [1:0] {IRTX_STD, IRTX_EXT, IRTX_LONG, IRTX_RSVD} irtx_mode_t;
	typedef enum {IRTX_IDLE, IRTX_FIRST, IRTX_SECOND} irtx_state_t;
endpackage

// ==== irtx_tick_if.sv ====
// Half-bit timer hand-off between frame engine and timer
`timescale 1ns/10ps
interface irtx_tick_if;
	logic run;
	logic [15:0] period;
	logic tick;
	modport engine (output run, output period, input tick);
	modport timer (input run, input period, output tick);
endinterface

// ==== irtx_half_timer.sv ====
// Sixteen-bit half-bit timer with compare match pulse
`timescale 1ns/10ps
module irtx_half_timer (
	input wire logic clk,
	input wire logic rst_n,
	irtx_tick_if.timer tif
);
	logic [15:0] count_reg;

	// ----------------------------------------
	// Counter and compare
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_reg <= 16'h0000;
		end else if (!tif.run || tif.tick) begin
			count_reg <= 16'h0000;
		end else begin
			count_reg <= count_reg + 16'h0001;
		end
	end

	assign tif.tick = tif.run && (count_reg == tif.period - 16'h0001);
endmodule

// ==== irtx_transmitter.sv ====
// Infrared remote frame transmitter, bi-phase serialiser with register port
`timescale 1ns/10ps
`include "irtx_defs.svh"
module irtx_transmitter import irtx_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	output logic timer_compare_output_pin,
	output logic busy
);
	irtx_tick_if tif ();

	logic [7:0] toggle_reg;
	logic [7:0] addr_reg;
	logic [7:0] cmd_reg;
	irtx_mode_t mode_reg;
	logic inv_reg;
	logic [15:0] halfbit_reg;
	logic done_reg;
	irtx_state_t state_reg;
	logic [35:0] shift_reg;
	logic [35:0] frame_next;
	logic [5:0] left_reg;
	logic [5:0] len_next;
	logic wave_reg;
	logic go;
	irtx_mode_t mode_sel;

	function automatic logic is_wr(input logic [3:0] a, input logic [3:0] off);
		is_wr = wr && (a == off);
	endfunction

	// Bits on air for one frame; the reserved mode never starts
	function automatic logic [5:0] frame_len(input irtx_mode_t m);
		case (m)
			IRTX_LONG: frame_len = `IRTX_LONG_LEN;
			default: frame_len = `IRTX_STD_LEN;
		endcase
	endfunction

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	always_comb begin
		go = is_wr(addr, `IRTX_OFF_CTRL) && wdata[`IRTX_CTRL_GO_BIT]
			&& state_reg == IRTX_IDLE;
	end

	// A go write carries its own mode, so the frame must use that one
	always_comb begin
		mode_sel = mode_reg;
		if (is_wr(addr, `IRTX_OFF_CTRL)) begin
			mode_sel = irtx_mode_t'(wdata[`IRTX_CTRL_MODE_LSB +: 2]);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_reg <= IRTX_STD;
			inv_reg <= 1'b0;
		end else if (is_wr(addr, `IRTX_OFF_CTRL) && state_reg == IRTX_IDLE) begin
			mode_reg <= irtx_mode_t'(wdata[`IRTX_CTRL_MODE_LSB +: 2]);
			inv_reg <= wdata[`IRTX_CTRL_INV_BIT];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			toggle_reg <= 8'h00;
			addr_reg <= 8'h00;
			cmd_reg <= 8'h00;
			halfbit_reg <= `IRTX_HALFBIT_RST;
		end else if (state_reg == IRTX_IDLE) begin
			// Fields are frozen during a frame so the word on air stays coherent
			if (is_wr(addr, `IRTX_OFF_TOGGLE)) toggle_reg <= wdata[7:0];
			if (is_wr(addr, `IRTX_OFF_ADDR)) addr_reg <= wdata[7:0];
			if (is_wr(addr, `IRTX_OFF_CMD)) cmd_reg <= wdata[7:0];
			if (is_wr(addr, `IRTX_OFF_HALFBIT) && wdata != 16'h0000) halfbit_reg <= wdata;
		end
	end

	// ----------------------------------------
	// Frame assembly, left aligned, MSB first
	// ----------------------------------------
	always_comb begin
		frame_next = 36'h0;
		len_next = `IRTX_STD_LEN;
		case (mode_sel)
			IRTX_STD: begin
				// Start bits fixed high, toggle from byte bit five
				frame_next[35:22] = {2'b11, toggle_reg[`IRTX_STD_TOGGLE_BIT],
					addr_reg[4:0], cmd_reg[5:0]};
			end
			IRTX_EXT: begin
				// Leading byte MSB is the first start bit, forced high
				frame_next[35:22] = {1'b1, toggle_reg[`IRTX_EXT_BANK_BIT],
					toggle_reg[`IRTX_EXT_TOGGLE_BIT], addr_reg[4:0], cmd_reg[5:0]};
			end
			IRTX_LONG: begin
				// Header: start, mode bits, toggle, padding to twenty bits
				frame_next[35:16] = {4'b1000, toggle_reg[0], 15'h0000};
				frame_next[15:0] = {addr_reg, cmd_reg};
				len_next = `IRTX_LONG_LEN;
			end
			default: begin
				frame_next = 36'h0;
				len_next = `IRTX_STD_LEN;
			end
		endcase
	end

	// ----------------------------------------
	// Bi-phase sequencer
	// ----------------------------------------
	assign tif.run = state_reg != IRTX_IDLE;
	assign tif.period = halfbit_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= IRTX_IDLE;
			shift_reg <= 36'h0;
			left_reg <= 6'h00;
			wave_reg <= 1'b0;
		end else begin
			case (state_reg)
				IRTX_IDLE: begin
					wave_reg <= 1'b0;
					if (go && mode_sel != IRTX_RSVD) begin
						shift_reg <= frame_next;
						left_reg <= len_next;
						wave_reg <= ~frame_next[35];
						state_reg <= IRTX_FIRST;
					end
				end
				IRTX_FIRST: begin
					if (tif.tick) begin
						wave_reg <= shift_reg[35];
						state_reg <= IRTX_SECOND;
					end
				end
				IRTX_SECOND: begin
					if (tif.tick) begin
						if (left_reg == 6'h01) begin
							wave_reg <= 1'b0;
							left_reg <= 6'h00;
							state_reg <= IRTX_IDLE;
						end else begin
							shift_reg <= {shift_reg[34:0], 1'b0};
							left_reg <= left_reg - 6'h01;
							wave_reg <= ~shift_reg[34];
							state_reg <= IRTX_FIRST;
						end
					end
				end
				default: state_reg <= IRTX_IDLE;
			endcase
		end
	end

	// Done flag: completion sets, write of one clears; set wins
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			done_reg <= 1'b0;
		end else if (state_reg == IRTX_SECOND && tif.tick && left_reg == 6'h01) begin
			done_reg <= 1'b1;
		end else if (is_wr(addr, `IRTX_OFF_STATUS) && wdata[0]) begin
			done_reg <= 1'b0;
		end
	end

	irtx_half_timer u_timer (
		.clk(clk),
		.rst_n(rst_n),
		.tif(tif)
	);

	// ----------------------------------------
	// Outputs and read port
	// ----------------------------------------
	// Registered so the pin never glitches when wave and invert move together
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			timer_compare_output_pin <= 1'b0;
		end else begin
			timer_compare_output_pin <= wave_reg ^ inv_reg;
		end
	end
	assign busy = state_reg != IRTX_IDLE;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 16'h0000;
		end else if (rd) begin
			case (addr)
				`IRTX_OFF_CTRL: rdata <= {12'h000, inv_reg, mode_reg, 1'b0};
				`IRTX_OFF_TOGGLE: rdata <= {8'h00, toggle_reg};
				`IRTX_OFF_ADDR: rdata <= {8'h00, addr_reg};
				`IRTX_OFF_CMD: rdata <= {8'h00, cmd_reg};
				`IRTX_OFF_STATUS: rdata <= {8'h00, 2'b00, left_reg[5:0]} | {14'h0, busy, done_reg};
				`IRTX_OFF_HALFBIT: rdata <= halfbit_reg;
				default: rdata <= 16'h0000;
			endcase
		end else begin
			rdata <= 16'h0000;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic [5:0] bits_sent;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) bits_sent <= 6'h00;
		else if (go) bits_sent <= 6'h00;
		else if (state_reg == IRTX_SECOND && tif.tick) bits_sent <= bits_sent + 6'h01;
	end

	mid_transition_a: assert property (@(posedge clk) disable iff (!rst_n)
		(state_reg == IRTX_FIRST && tif.tick) |=> (wave_reg != $past(wave_reg)))
		else $error("no mid-bit transition");
	std_start_a: assert property (@(posedge clk) disable iff (!rst_n)
		(go && mode_sel == IRTX_STD) |=> (shift_reg[35:34] == 2'b11))
		else $error("standard start bits not high");
	std_length_a: assert property (@(posedge clk) disable iff (!rst_n)
		(state_reg == IRTX_SECOND && tif.tick && left_reg == 6'h01 && mode_reg != IRTX_LONG)
		|=> (bits_sent == 6'h0E))
		else $error("standard frame not fourteen bits");
	long_length_a: assert property (@(posedge clk) disable iff (!rst_n)
		(state_reg == IRTX_SECOND && tif.tick && left_reg == 6'h01 && mode_reg == IRTX_LONG)
		|=> (bits_sent == 6'h24))
		else $error("long frame not header plus sixteen bits");
	std_toggle_a: assert property (@(posedge clk) disable iff (!rst_n)
		(go && mode_sel == IRTX_STD) |=> (shift_reg[33] == $past(toggle_reg[5])))
		else $error("toggle not from bit five");
	ext_bank_a: assert property (@(posedge clk) disable iff (!rst_n)
		(go && mode_sel == IRTX_EXT) |=> (shift_reg[35] && shift_reg[34] == $past(toggle_reg[6])))
		else $error("bank select wrong");
	long_data_a: assert property (@(posedge clk) disable iff (!rst_n)
		(go && mode_sel == IRTX_LONG) |=> (shift_reg[15:0] == {$past(addr_reg), $past(cmd_reg)}))
		else $error("long data word wrong");
	std_cmd_a: assert property (@(posedge clk) disable iff (!rst_n)
		(go && mode_sel == IRTX_STD) |=> (shift_reg[27:22] == $past(cmd_reg[5:0])))
		else $error("command field wrong");
	std_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
		(go && mode_sel == IRTX_STD) |=> (shift_reg[32:28] == $past(addr_reg[4:0])))
		else $error("address field wrong");
	pin_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
		(state_reg == IRTX_IDLE && !go) |=> (wave_reg == 1'b0))
		else $error("pin active while idle");

	// ----------------------------------------
	// Frame loading checks
	// ----------------------------------------
	long_header_a: assert property (@(posedge clk) disable iff (!rst_n)
		(go && mode_sel == IRTX_LONG)
		|=> (shift_reg[35:16] == {4'b1000, $past(toggle_reg[0]), 15'h0000}))
		else $error("long header wrong");
	long_toggle_a: assert property (@(posedge clk) disable iff (!rst_n)
		(go && mode_sel == IRTX_LONG) |=> (shift_reg[31] == $past(toggle_reg[0])))
		else $error("long toggle not taken directly");
	long_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
		(go && mode_sel == IRTX_LONG) |=> (shift_reg[15:8] == $past(addr_reg)))
		else $error("long address wrong");
	long_cmd_a: assert property (@(posedge clk) disable iff (!rst_n)
		(go && mode_sel == IRTX_LONG) |=> (shift_reg[7:0] == $past(cmd_reg)))
		else $error("long command wrong");
	ext_toggle_a: assert property (@(posedge clk) disable iff (!rst_n)
		(go && mode_sel == IRTX_EXT) |=> (shift_reg[33] == $past(toggle_reg[5])))
		else $error("extended toggle wrong");
	ext_fields_a: assert property (@(posedge clk) disable iff (!rst_n)
		(go && mode_sel == IRTX_EXT)
		|=> (shift_reg[32:22] == {$past(addr_reg[4:0]), $past(cmd_reg[5:0])}))
		else $error("extended fields wrong");
	frame_len_a: assert property (@(posedge clk) disable iff (!rst_n)
		(go && mode_sel != IRTX_RSVD) |=> (left_reg == frame_len(mode_reg)))
		else $error("frame length not loaded");
	std_tail_a: assert property (@(posedge clk) disable iff (!rst_n)
		(go && mode_sel != IRTX_LONG && mode_sel != IRTX_RSVD)
		|=> (shift_reg[21:0] == 22'h000000))
		else $error("short frame has stray bits");
	reserved_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
		(go && mode_sel == IRTX_RSVD) |=> (state_reg == IRTX_IDLE))
		else $error("reserved mode started a frame");
	start_tick_a: assert property (@(posedge clk) disable iff (!rst_n)
		(go && mode_sel != IRTX_RSVD && halfbit_reg != 16'h0001) |=> !tif.tick)
		else $error("first half cut short");

	// ----------------------------------------
	// Serialiser checks
	// ----------------------------------------
	first_half_a: assert property (@(posedge clk) disable iff (!rst_n)
		(state_reg == IRTX_FIRST) |-> (wave_reg == !shift_reg[35]))
		else $error("first half not inverse of bit");
	second_half_a: assert property (@(posedge clk) disable iff (!rst_n)
		(state_reg == IRTX_SECOND) |-> (wave_reg == shift_reg[35]))
		else $error("second half not equal to bit");
	shift_order_a: assert property (@(posedge clk) disable iff (!rst_n)
		(state_reg == IRTX_SECOND && tif.tick && left_reg != 6'h01)
		|=> (shift_reg[35] == $past(shift_reg[34]) && state_reg == IRTX_FIRST))
		else $error("bits not sent in order");
	left_count_a: assert property (@(posedge clk) disable iff (!rst_n)
		(state_reg == IRTX_SECOND && tif.tick && left_reg != 6'h01) |=> (left_reg == $past(left_reg) - 6'h01))
		else $error("bit count not stepped");
	wave_steady_a: assert property (@(posedge clk) disable iff (!rst_n)
		(state_reg != IRTX_IDLE && !tif.tick) |=> $stable(wave_reg))
		else $error("wave moved between ticks");
	tick_spacing_a: assert property (@(posedge clk) disable iff (!rst_n)
		(tif.tick && halfbit_reg != 16'h0001) |=> !tif.tick)
		else $error("half bit too short");
	timer_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
		(state_reg == IRTX_IDLE) |-> !tif.tick)
		else $error("timer ticks while idle");
	frame_end_a: assert property (@(posedge clk) disable iff (!rst_n)
		(state_reg == IRTX_SECOND && tif.tick && left_reg == 6'h01)
		|=> (state_reg == IRTX_IDLE && done_reg && !wave_reg && left_reg == 6'h00))
		else $error("frame did not end cleanly");
	end_count_a: assert property (@(posedge clk) disable iff (!rst_n)
		(state_reg == IRTX_SECOND && tif.tick && left_reg == 6'h01)
		|=> (bits_sent == frame_len(mode_reg)))
		else $error("bit total differs from mode");

	// ----------------------------------------
	// Freeze, pin and half-bit period checks
	// ----------------------------------------
	fields_frozen_a: assert property (@(posedge clk) disable iff (!rst_n)
		(state_reg != IRTX_IDLE)
		|=> ($stable(toggle_reg) && $stable(addr_reg) && $stable(cmd_reg)))
		else $error("frame fields changed on air");
	mode_frozen_a: assert property (@(posedge clk) disable iff (!rst_n)
		(state_reg != IRTX_IDLE)
		|=> ($stable(mode_reg) && $stable(inv_reg) && $stable(halfbit_reg)))
		else $error("mode or period changed on air");
	pin_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
		1'b1 |=> (timer_compare_output_pin == ($past(wave_reg) ^ $past(inv_reg))))
		else $error("pin does not follow wave");
	halfbit_nonzero_a: assert property (@(posedge clk) disable iff (!rst_n)
		(halfbit_reg != 16'h0000))
		else $error("half bit period is zero");
endmodule

// ==== irtx_ir_receiver_model.sv ====
// Behavioural appliance receiver that decodes the bi-phase pin waveform
`timescale 1ns/10ps
module irtx_ir_receiver_model (
	input wire logic clk,
	input wire logic pin,
	input wire logic busy,
	input wire logic [15:0] half,
	output logic [63:0] bits,
	output int nbits,
	output int bad
);
	// ----------------------------------------
	// Mid-half sampling and decode
	// ----------------------------------------
	// Busy marks the frame because the idle level equals the first half of a one
	logic busy_q;
	logic first_half;
	int k;
	initial begin
		busy_q = 1'b0;
		first_half = 1'b0;
		k = 0;
		bits = '0;
		nbits = 0;
		bad = 0;
	end
	always @(posedge clk) begin
		if (busy && !busy_q) begin
			k = 0;
			nbits = 0;
			bits = '0;
			bad = 0;
		end
		busy_q <= busy;
		if (busy) begin
			if (k % half == half / 2) begin
				if ((k / half) % 2 == 0) begin
					first_half = pin;
				end else begin
					bits = {bits[62:0], pin};
					nbits++;
					if (pin == first_half) bad++;
				end
			end
			k++;
		end
	end
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the infrared remote frame transmitter
`timescale 1ns/10ps
`include "irtx_defs.svh"
module tb_top import irtx_pkg::*; ;
	// ----------------------------------------
	// Signals and instances
	// ----------------------------------------
	// Short half bit keeps the long frame near three hundred cycles
	localparam logic [15:0] HALF = 16'h0004;
	logic clk, rst_n, wr, rd, pin, busy;
	logic [3:0] addr;
	logic [15:0] wdata, rdata, d;
	logic [63:0] rx_bits;
	int rx_n, rx_bad, fail_count, compares;
	irtx_transmitter u_irtx_transmitter (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .timer_compare_output_pin(pin), .busy(busy));
	irtx_ir_receiver_model u_irtx_ir_receiver_model (.clk(clk), .pin(pin), .busy(busy),
		.half(HALF), .bits(rx_bits), .nbits(rx_n), .bad(rx_bad));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic reg_wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic reg_rd(input logic [3:0] a, output logic [15:0] v);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic wait_busy(input logic lvl);
		for (int i = 0; i < 400 && busy !== lvl; i++) @(posedge clk);
		if (busy !== lvl) begin
			fail_count++;
			$display("CHECK FAILED busy expected %b seen %b", lvl, busy);
			give_verdict();
		end
	endtask
	task automatic send(input irtx_mode_t m, input logic [15:0] tog, input logic [15:0] ad,
		input logic [15:0] cm, input logic [63:0] exp, input int n);
		logic [15:0] s;
		reg_wr(`IRTX_OFF_TOGGLE, tog);
		reg_wr(`IRTX_OFF_ADDR, ad);
		reg_wr(`IRTX_OFF_CMD, cm);
		reg_wr(`IRTX_OFF_CTRL, {13'h0000, m, 1'b1});
		wait_busy(1'b1);
		reg_wr(`IRTX_OFF_CTRL, 16'h0003);
		wait_busy(1'b0);
		@(posedge clk);
		#1;
		chk("frame bits", exp, rx_bits);
		chk("bit count", 64'(n), 64'(rx_n));
		chk("coding faults", 64'h0, 64'(rx_bad));
		chk("idle pin", 64'h0, {63'h0, pin});
		reg_rd(`IRTX_OFF_STATUS, s);
		chk("status done", 64'h1, {48'h0, s});
		chk("no restart", 64'h0, {63'h0, busy});
		reg_wr(`IRTX_OFF_STATUS, 16'h0001);
		$display("test %s frame done", m.name());
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rst_n = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 4'h0;
		wdata = 16'h0000;
		fail_count = 0;
		compares = 0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		reg_rd(`IRTX_OFF_HALFBIT, d);
		chk("halfbit reset", 64'(`IRTX_HALFBIT_RST), {48'h0, d});
		reg_wr(`IRTX_OFF_HALFBIT, 16'h0000);
		reg_rd(`IRTX_OFF_HALFBIT, d);
		chk("halfbit zero refused", 64'(`IRTX_HALFBIT_RST), {48'h0, d});
		reg_wr(`IRTX_OFF_HALFBIT, HALF);
		reg_rd(4'hF, d);
		chk("unmapped read", 64'h0, {48'h0, d});
		reg_wr(`IRTX_OFF_CTRL, 16'h0007);
		repeat (3) @(posedge clk);
		chk("reserved mode ignored", 64'h0, {63'h0, busy});
		reg_wr(`IRTX_OFF_CTRL, 16'h0008);
		reg_rd(`IRTX_OFF_CTRL, d);
		chk("ctrl readback", 64'h0008, {48'h0, d});
		chk("inverted idle pin", 64'h1, {63'h0, pin});
		reg_wr(`IRTX_OFF_CTRL, 16'h0000);
		$display("test register access done");
		send(IRTX_STD, 16'h0000, 16'h0000, 16'h000C,
			{50'h0, 2'b11, 1'b0, 5'h00, 6'h0C}, 14);
		send(IRTX_STD, 16'h0020, 16'h0005, 16'h003F,
			{50'h0, 2'b11, 1'b1, 5'h05, 6'h3F}, 14);
		send(IRTX_EXT, 16'h00C0, 16'h001F, 16'h0021,
			{50'h0, 3'b110, 5'h1F, 6'h21}, 14);
		send(IRTX_EXT, 16'h00A0, 16'h0005, 16'h0000,
			{50'h0, 3'b101, 5'h05, 6'h00}, 14);
		send(IRTX_EXT, 16'h0080, 16'h0011, 16'h002A,
			{50'h0, 3'b100, 5'h11, 6'h2A}, 14);
		send(IRTX_LONG, 16'h0001, 16'h00A5, 16'h00F6,
			{28'h0, 4'b1000, 1'b1, 15'h0000, 8'hA5, 8'hF6}, 36);
		send(IRTX_LONG, 16'h0000, 16'h0005, 16'h0081,
			{28'h0, 4'b1000, 1'b0, 15'h0000, 8'h05, 8'h81}, 36);
		reg_rd(`IRTX_OFF_STATUS, d);
		chk("status cleared", 64'h0, {48'h0, d});
		$display("test status clear done");
		give_verdict();
	end
endmodule
